// File: ccdiv_pkg.sv
// ccdiv_pkg: constants and carrier types for the channel clock divider
// assumes an 8-bit register port addressed by the documented offsets
`default_nettype none
package ccdiv_pkg;
	localparam logic [9:0] CCDIV_PHASE_OFFS   = 10'h190;
	localparam logic [9:0] CCDIV_MODE_OFFS    = 10'h191;
	localparam int         CCDIV_LOW_LSB      = 4;
	localparam int         CCDIV_HIGH_LSB     = 0;
	localparam int         CCDIV_BYPASS_BIT   = 7;
	localparam int         CCDIV_IGNSYNC_BIT  = 6;
	localparam int         CCDIV_FORCE_BIT    = 5;
	localparam int         CCDIV_STARTHI_BIT  = 4;
	localparam logic [7:0] CCDIV_PHASE_RESET  = 8'h77;
	localparam logic [7:0] CCDIV_MODE_RESET   = 8'h00;

	typedef struct packed {
		logic       wr_en;
		logic [9:0] addr;
		logic [7:0] wdata;
	} ccdiv_wr_s;

	typedef enum logic [0:0] {
		CCDIV_PH_LOW  = 1'b0,
		CCDIV_PH_HIGH = 1'b1
	} ccdiv_phase_e;
endpackage
`default_nettype wire

// File: ccdiv_top.sv
// ccdiv_top: programmable low/high phase channel divider with bypass,
// alignment pulse response, forced static level and start level
// assumes register writes and the alignment pulse are synchronous to sys_clk
// Operation
// RULE1: the output stays low for the low-cycles field plus one cycles, reset 8.
// RULE2: the output stays high for the high-cycles field plus one cycles, reset 8.
// RULE3: bypass set passes the input clock straight out and idles the divider; the code outputs a toggle per sys_clk cycle instead.
// RULE4: with ignore-alignment clear the divider restarts on the alignment pulse.
// RULE5: software sets ignore-alignment whenever it uses the force bit.
// RULE6: with force set, start-high clear gives a low forced level, set gives a high one.
// RULE7: force has no effect under bypass while inversion stays available.
// RULE8: the start-high bit picks the level the divided clock begins with.
// RULE9: start-high zero begins low, one begins high.
// RULE10: the output alternates low and high, period is the sum of both phases.
`timescale 1ns/10ps
`default_nettype none
module ccdiv_top
	import ccdiv_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire ccdiv_wr_s  reg_wr,
	input  wire logic [9:0] reg_rd_addr,
	input  wire logic       align_pulse,
	input  wire logic       invert_out,
	output var  logic [7:0] reg_rdata,
	output var  logic       div_out
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0]   phase_reg, next_phase_reg;
	logic [7:0]   mode_reg, next_mode_reg;
	logic [7:0]   next_reg_rdata;

	always_comb begin
		next_phase_reg = phase_reg;
		next_mode_reg = mode_reg;
		if (reg_wr.wr_en && reg_wr.addr == CCDIV_PHASE_OFFS)
			next_phase_reg = reg_wr.wdata;
		if (reg_wr.wr_en && reg_wr.addr == CCDIV_MODE_OFFS)
			next_mode_reg = reg_wr.wdata;
		case (reg_rd_addr)
			CCDIV_PHASE_OFFS: next_reg_rdata = phase_reg;
			CCDIV_MODE_OFFS:  next_reg_rdata = mode_reg;
			default:          next_reg_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			phase_reg <= CCDIV_PHASE_RESET;
			mode_reg  <= CCDIV_MODE_RESET;
			reg_rdata <= 8'h00;
		end else begin
			phase_reg <= next_phase_reg;
			mode_reg  <= next_mode_reg;
			reg_rdata <= next_reg_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [3:0]   low_len, high_len;
	logic         bypass, ign_sync, force_on, start_hi;
	assign low_len  = phase_reg[CCDIV_LOW_LSB +: 4];
	assign high_len = phase_reg[CCDIV_HIGH_LSB +: 4];
	assign bypass   = mode_reg[CCDIV_BYPASS_BIT];
	assign ign_sync = mode_reg[CCDIV_IGNSYNC_BIT];
	assign force_on = mode_reg[CCDIV_FORCE_BIT];
	assign start_hi = mode_reg[CCDIV_STARTHI_BIT];

	ccdiv_phase_e phase, next_phase;
	logic [3:0]   cnt, next_cnt;
	logic         sync_act;
	logic         next_div_out;
	logic         core;
	logic         byp_tgl, next_byp_tgl;

	// the alignment pulse restarts the count at the chosen start level
	assign sync_act = align_pulse && !ign_sync; // RULE4

	always_comb begin
		next_phase = phase;
		next_cnt = cnt;
		if (bypass) begin
			// divider idles and is parked at the start level
			next_phase = start_hi ? CCDIV_PH_HIGH : CCDIV_PH_LOW; // RULE3
			next_cnt = 4'h0;
		end else if (sync_act) begin
			next_phase = start_hi ? CCDIV_PH_HIGH : CCDIV_PH_LOW; // RULE8 RULE9
			next_cnt = 4'h0;
		end else if (phase == CCDIV_PH_LOW) begin
			if (cnt >= low_len) begin // RULE1 RULE10
				next_phase = CCDIV_PH_HIGH;
				next_cnt = 4'h0;
			end else
				next_cnt = cnt + 4'h1;
		end else begin
			if (cnt >= high_len) begin // RULE2 RULE10
				next_phase = CCDIV_PH_LOW;
				next_cnt = 4'h0;
			end else
				next_cnt = cnt + 4'h1;
		end
		// force works only while the pulse is ignored; software keeps both set
		if (force_on && ign_sync) // RULE5 RULE6
			core = start_hi;
		else
			core = (next_phase == CCDIV_PH_HIGH);
		// a real input clock cannot pass through logic, so a toggle per
		// cycle stands in for it; polarity inversion still applies on top
		next_byp_tgl = bypass ? ~byp_tgl : 1'b0; // RULE3
		if (bypass) // RULE3 RULE7
			next_div_out = next_byp_tgl ^ invert_out;
		else
			next_div_out = core ^ invert_out;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			phase   <= CCDIV_PH_LOW;
			cnt     <= 4'h0;
			byp_tgl <= 1'b0;
			div_out <= 1'b0;
		end else begin
			phase   <= next_phase;
			cnt     <= next_cnt;
			byp_tgl <= next_byp_tgl;
			div_out <= next_div_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic past_ok;
	always_ff @(posedge sys_clk) begin
		past_ok <= rst_n;
	end

	AST_RESET_PHASE: assert property (@(posedge sys_clk) // RULE1
		!rst_n |=> phase_reg == CCDIV_PHASE_RESET)
		else $error("phase register reset value wrong");

	AST_LOW_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
		(phase == CCDIV_PH_HIGH && next_phase == CCDIV_PH_LOW && !sync_act
		 && !bypass) |=> (cnt == 4'h0 && phase == CCDIV_PH_LOW))
		else $error("low phase did not restart count");

	AST_HIGH_END: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE2
		(phase == CCDIV_PH_HIGH && cnt == high_len && !bypass && !sync_act)
		|=> phase == CCDIV_PH_LOW)
		else $error("high phase length wrong");

	AST_BYPASS_TOG: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
		(bypass && past_ok) ##1 (bypass && $stable(invert_out))
		|=> div_out != $past(div_out))
		else $error("bypass output not passing clock");

	AST_BYPASS_INV: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE7
		(bypass && past_ok) ##1 (bypass && $changed(invert_out))
		|=> div_out == $past(div_out))
		else $error("inversion not applied in bypass");

	AST_BYP_PARK: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
		bypass |=> (cnt == 4'h0 && phase == ($past(start_hi) ?
		CCDIV_PH_HIGH : CCDIV_PH_LOW)))
		else $error("bypassed divider not parked");

	AST_SYNC_RESTART: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE4
		(sync_act && !bypass) |=> (cnt == 4'h0 && phase == (start_hi ?
		CCDIV_PH_HIGH : CCDIV_PH_LOW)))
		else $error("alignment pulse not obeyed");

	AST_IGNORE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE4
		(ign_sync && !bypass && phase == CCDIV_PH_LOW && cnt < low_len)
		|=> cnt == $past(cnt) + 4'h1)
		else $error("ignored pulse disturbed count");

	AST_FORCE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
		(force_on && ign_sync && !bypass) |=> div_out ==
		($past(start_hi) ^ $past(invert_out)))
		else $error("forced level wrong");

	AST_START: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE9
		(sync_act && !bypass && !force_on) |=> div_out ==
		($past(start_hi) ^ $past(invert_out)))
		else $error("start level wrong");

	////////////////////////////////////////////////////////////////////////
	// phase bookkeeping and register path checks; the mid-phase length
	// change allowed by software is why no upper bound is put on cnt
	AST_LOW_END: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
		(phase == CCDIV_PH_LOW && cnt == low_len && !bypass && !sync_act)
		|=> phase == CCDIV_PH_HIGH)
		else $error("low phase length wrong");

	AST_LOW_CNT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
		(!sync_act && !bypass && phase == CCDIV_PH_LOW && cnt < low_len)
		|=> (phase == CCDIV_PH_LOW && cnt == $past(cnt) + 4'h1))
		else $error("low phase count skipped");

	AST_IGN_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE4
		(ign_sync && !bypass && phase == CCDIV_PH_HIGH && cnt < high_len)
		|=> (phase == CCDIV_PH_HIGH && cnt == $past(cnt) + 4'h1))
		else $error("ignored pulse disturbed high phase");

	AST_FOLLOW: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE10
		(!bypass && !(force_on && ign_sync)) |=> div_out ==
		((phase == CCDIV_PH_HIGH) ^ $past(invert_out)))
		else $error("output does not follow phase");

	AST_RESET_OUT: assert property (@(posedge sys_clk) // RULE9
		!rst_n |=> (div_out == 1'b0 && reg_rdata == 8'h00 &&
		mode_reg == CCDIV_MODE_RESET))
		else $error("mode or outputs not reset");

	AST_WR_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
		(reg_wr.wr_en && reg_wr.addr == CCDIV_MODE_OFFS)
		|=> mode_reg == $past(reg_wr.wdata))
		else $error("mode write lost");

	AST_RD_PHASE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
		reg_rd_addr == CCDIV_PHASE_OFFS |=> reg_rdata == $past(phase_reg))
		else $error("phase register readback wrong");

	AST_RD_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE8
		reg_rd_addr == CCDIV_MODE_OFFS |=> reg_rdata == $past(mode_reg))
		else $error("mode register readback wrong");

	COV_BYPASS: cover property (@(posedge sys_clk) disable iff (!rst_n)
		bypass ##1 bypass);
	COV_SYNC: cover property (@(posedge sys_clk) disable iff (!rst_n)
		sync_act && !bypass);
	COV_FORCE: cover property (@(posedge sys_clk) disable iff (!rst_n)
		force_on && ign_sync);
	COV_WRAP: cover property (@(posedge sys_clk) disable iff (!rst_n)
		phase == CCDIV_PH_HIGH ##1 phase == CCDIV_PH_LOW);
	COV_BYP_INV: cover property (@(posedge sys_clk) disable iff (!rst_n)
		bypass ##1 (bypass && $changed(invert_out)));
endmodule
`default_nettype wire

// File: ccdiv_tb.sv
// ccdiv_tb: register and waveform checks for the channel clock divider
// assumes ccdiv_pkg is compiled first; inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ccdiv_pkg::*;
	logic       sys_clk;
	logic       rst_n;
	ccdiv_wr_s  reg_wr;
	logic [9:0] reg_rd_addr;
	logic       align_pulse;
	logic       invert_out;
	logic [7:0] reg_rdata;
	logic       div_out;
	int         miscompares;
	int         tests_run;
	int         n;

	ccdiv_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
		.reg_rd_addr(reg_rd_addr), .align_pulse(align_pulse),
		.invert_out(invert_out), .reg_rdata(reg_rdata), .div_out(div_out));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		reg_wr = '{wr_en: 1'b1, addr: a, wdata: d};
		@(negedge sys_clk);
		reg_wr.wr_en = 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		reg_rd_addr = a;
		@(negedge sys_clk);
		chk(reg_rdata, exp);
	endtask

	// skips to a run of lvl unless already in one, then counts it; 64 means it never ended
	task automatic run_len(input logic lvl, output int len);
		len = 0;
		while (div_out !== lvl && len < 64) begin
			@(negedge sys_clk);
			len++;
		end
		len = 0;
		while (div_out === lvl && len < 64) begin
			@(negedge sys_clk);
			len++;
		end
	endtask

	task automatic align(input logic [7:0] mode, input logic exp);
		wr(CCDIV_MODE_OFFS, mode);
		align_pulse = 1'b1;
		@(negedge sys_clk);
		align_pulse = 1'b0;
		chk({7'h0, div_out}, {7'h0, exp});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		miscompares = 0;
		tests_run = 0;
		rst_n = 1'b0;
		reg_wr = '0;
		reg_rd_addr = '0;
		align_pulse = 1'b0;
		invert_out = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		rd(CCDIV_PHASE_OFFS, CCDIV_PHASE_RESET);
		rd(CCDIV_MODE_OFFS, CCDIV_MODE_RESET);
		rd(10'h0FC, 8'h00);
		run_len(1'b1, n);
		chk(n[7:0], 8'h08);
		run_len(1'b0, n);
		chk(n[7:0], 8'h08);
		wr(CCDIV_PHASE_OFFS, 8'h21);
		rd(CCDIV_PHASE_OFFS, 8'h21);
		run_len(1'b1, n);
		chk(n[7:0], 8'h02);
		run_len(1'b0, n);
		chk(n[7:0], 8'h03);
		wr(CCDIV_PHASE_OFFS, 8'h44);
		align(8'h10, 1'b1);
		align(8'h00, 1'b0);
		wr(CCDIV_MODE_OFFS, 8'h70);
		align_pulse = 1'b1;
		@(negedge sys_clk);
		align_pulse = 1'b0;
		run_len(1'b1, n);
		chk(n[7:0], 8'h40);
		invert_out = 1'b1;
		run_len(1'b0, n);
		chk(n[7:0], 8'h40);
		invert_out = 1'b0;
		wr(CCDIV_MODE_OFFS, 8'h60);
		run_len(1'b0, n);
		chk(n[7:0], 8'h40);
		wr(CCDIV_MODE_OFFS, 8'hF0);
		run_len(1'b1, n);
		chk(n[7:0], 8'h01);
		run_len(1'b0, n);
		chk(n[7:0], 8'h01);
		invert_out = 1'b1;
		run_len(1'b1, n);
		chk(n[7:0], 8'h02);
		invert_out = 1'b0;
		rd(CCDIV_MODE_OFFS, 8'hF0);
		final_report();
	end

	// the sequence needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		miscompares++;
		final_report();
	end
endmodule
`default_nettype wire
